//--- design/link_ctl_pkg.sv
// Notes on behaviour
// R1: Reserved bits 31:30,27:26,15:8,2 read zero
// R2: Data-link-active bit 29 always zero
// R3: Slot clock bit 28 read-only, loadable
// R4: Lane count field reads 000001
// R5: Rate code field reads 0001
// R6: Bit 7 extended sync, read/write, reset 0
// R7: Bit 6 shared refclk select, reset 0
// R8: Software sets both ends alike, then retrains
// R9: Exit latencies follow shared refclk select
// R10: Retrain bit 5 reads zero, no effect
// R11: Link-off bit 4 reads zero, no effect
// R12: Bit 3 completion boundary, 64 or 128
// R13: Bits 1:0 power control, reset 00
// R14: Writes to fixed bits are ignored
`default_nettype none
package link_ctl_pkg;
  localparam logic [11:0] LINK_CSR_OFFSET = 12'h0d0;
  localparam logic [31:0] LINK_CSR_RESET = 32'h0011_0000;
  localparam int BIT_DL_UP = 29;
  localparam int BIT_SLOT_CLK = 28;
  localparam int LANE_LSB = 20;
  localparam int LANE_MSB = 25;
  localparam int RATE_LSB = 16;
  localparam int RATE_MSB = 19;
  localparam int BIT_EXT_SYNC = 7;
  localparam int BIT_SHARED_CLK = 6;
  localparam int BIT_RETRAIN = 5;
  localparam int BIT_LINK_OFF = 4;
  localparam int BIT_CPL_BOUND = 3;
  localparam int PWR_LSB = 0;
  localparam int PWR_MSB = 1;
  localparam logic [5:0] LANE_X1 = 6'h01;
  localparam logic [3:0] RATE_2G5 = 4'h1;
  localparam logic [1:0] PWR_OFF = 2'h0;
  localparam logic [1:0] PWR_L0S = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Exit latency codes; arbitrary defaults, per clock mode
  localparam logic [2:0] L0S_LAT_ASYNC = 3'h3;
  localparam logic [2:0] L0S_LAT_COMMON = 3'h3;
  localparam logic [2:0] L1_LAT_ASYNC = 3'h0;
  localparam logic [2:0] L1_LAT_COMMON = 3'h0;

  typedef struct packed {
    logic ext_sync;
    logic shared_refclk_select;
    logic completion_boundary_size;
    logic [1:0] active_power_state_control;
  } link_ctl_t;

  typedef struct packed {
    logic [2:0] l0s_exit;
    logic [2:0] l1_exit;
  } exit_lat_t;
endpackage
`default_nettype wire

//--- design/link_csr_word.sv
`timescale 1ns/1ns
`default_nettype none
module link_csr_word (
  // Control and strap
  input wire link_ctl_pkg::link_ctl_t ctl,
  input wire logic slot_refclk_shared,
  // Assembled word
  output logic [31:0] word
);
  always_comb begin
    word = '0; // R1
    word[link_ctl_pkg::BIT_DL_UP] = 1'b0; // R2
    word[link_ctl_pkg::BIT_SLOT_CLK] = slot_refclk_shared; // R3
    word[link_ctl_pkg::LANE_MSB:link_ctl_pkg::LANE_LSB] = link_ctl_pkg::LANE_X1; // R4
    word[link_ctl_pkg::RATE_MSB:link_ctl_pkg::RATE_LSB] = link_ctl_pkg::RATE_2G5; // R5
    word[link_ctl_pkg::BIT_EXT_SYNC] = ctl.ext_sync; // R6
    word[link_ctl_pkg::BIT_SHARED_CLK] = ctl.shared_refclk_select; // R7
    word[link_ctl_pkg::BIT_RETRAIN] = 1'b0; // R10
    word[link_ctl_pkg::BIT_LINK_OFF] = 1'b0; // R11
    word[link_ctl_pkg::BIT_CPL_BOUND] = ctl.completion_boundary_size; // R12
    word[link_ctl_pkg::PWR_MSB:link_ctl_pkg::PWR_LSB] = ctl.active_power_state_control; // R13
  end
endmodule
`default_nettype wire

//--- design/pcie_link_control_status_reg.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module pcie_link_control_status_reg (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite write address
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Board configuration load
  input wire logic SLOT_CLK_LOAD,
  input wire logic SLOT_CLK_VALUE,
  // Control outputs to the link logic
  output logic EXT_SYNC,
  output logic SHARED_REFCLK_SELECT,
  output logic COMPLETION_BOUNDARY_SIZE,
  output logic L0S_ENTRY_ENABLE,
  output logic [2:0] L0S_EXIT_LATENCY,
  output logic [2:0] L1_EXIT_LATENCY
);
  link_ctl_pkg::link_ctl_t ctl_r, ctl_nxt;
  logic slot_r, slot_nxt;
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  link_ctl_pkg::exit_lat_t lat_r, lat_nxt;
  logic [31:0] csr_word;
  logic do_write;
  logic addr_hit_w;

  link_csr_word link_csr_word_inst (
    .ctl(ctl_r),
    .slot_refclk_shared(slot_r),
    .word(csr_word)
  );

  // One write at a time; stall new address/data until response taken
  assign AWREADY = !aw_hold_r && !bvalid_r;
  assign WREADY = !w_hold_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;

  assign EXT_SYNC = ctl_r.ext_sync;
  assign SHARED_REFCLK_SELECT = ctl_r.shared_refclk_select;
  assign COMPLETION_BOUNDARY_SIZE = ctl_r.completion_boundary_size;
  // Reserved power codes enable nothing
  assign L0S_ENTRY_ENABLE = (ctl_r.active_power_state_control == link_ctl_pkg::PWR_L0S);
  assign L0S_EXIT_LATENCY = lat_r.l0s_exit;
  assign L1_EXIT_LATENCY = lat_r.l1_exit;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    if (AWVALID && AWREADY) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = WDATA;
      wstrb_nxt = WSTRB;
    end
    do_write = aw_hold_r && w_hold_r;
    addr_hit_w = (awaddr_r[11:2] == link_ctl_pkg::LINK_CSR_OFFSET[11:2]);
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_hit_w ? link_ctl_pkg::RESP_OKAY : link_ctl_pkg::RESP_SLVERR;
    end
  end

  // Only the writable low byte takes data; other bits are fixed
  always_comb begin
    ctl_nxt = ctl_r;
    if (do_write && addr_hit_w && wstrb_r[0]) begin // R14
      ctl_nxt.ext_sync = wdata_r[link_ctl_pkg::BIT_EXT_SYNC]; // R6
      ctl_nxt.shared_refclk_select = wdata_r[link_ctl_pkg::BIT_SHARED_CLK]; // R7
      ctl_nxt.completion_boundary_size = wdata_r[link_ctl_pkg::BIT_CPL_BOUND]; // R12
      ctl_nxt.active_power_state_control = wdata_r[link_ctl_pkg::PWR_MSB:link_ctl_pkg::PWR_LSB]; // R13
    end
    slot_nxt = slot_r;
    if (SLOT_CLK_LOAD) begin
      slot_nxt = SLOT_CLK_VALUE; // R3
    end
    lat_nxt.l0s_exit = ctl_r.shared_refclk_select ? link_ctl_pkg::L0S_LAT_COMMON
                                                  : link_ctl_pkg::L0S_LAT_ASYNC; // R9
    lat_nxt.l1_exit = ctl_r.shared_refclk_select ? link_ctl_pkg::L1_LAT_COMMON
                                                 : link_ctl_pkg::L1_LAT_ASYNC; // R9
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      if (ARADDR[11:2] == link_ctl_pkg::LINK_CSR_OFFSET[11:2]) begin
        rdata_nxt = csr_word; // R1
        rresp_nxt = link_ctl_pkg::RESP_OKAY;
      end else begin
        rdata_nxt = '0;
        rresp_nxt = link_ctl_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_r <= '0;
      slot_r <= 1'b0;
      // Reset selects the asynchronous clock, so report its latencies
      lat_r <= {link_ctl_pkg::L0S_LAT_ASYNC, link_ctl_pkg::L1_LAT_ASYNC}; // R9
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= '0;
      rvalid_r <= 1'b0;
      rresp_r <= '0;
      rdata_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
      slot_r <= slot_nxt;
      lat_r <= lat_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

//--- verification/link_csr_chk.sv
`timescale 1ns/1ns
`default_nettype none
module link_csr_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Read channel
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  // Link controls
  input wire logic EXT_SYNC,
  input wire logic SHARED_REFCLK_SELECT,
  input wire logic COMPLETION_BOUNDARY_SIZE,
  input wire logic L0S_ENTRY_ENABLE,
  input wire logic [2:0] L0S_EXIT_LATENCY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire ok = RVALID && RRESP == 2'h0;
  property p_rsv; RVALID |-> {RDATA[31:30], RDATA[27:26], RDATA[15:8], RDATA[2]} == 13'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_dl; RVALID |-> !RDATA[29]; endproperty
  a_dl: assert property (p_dl) else $error("link active bit set");
  property p_fix; ok |-> RDATA[25:16] == 10'h011; endproperty
  a_fix: assert property (p_fix) else $error("lane or rate wrong");
  property p_nop; RVALID |-> RDATA[5:4] == 2'h0; endproperty
  a_nop: assert property (p_nop) else $error("retrain or off bit set");
  property p_ctl; ok |-> {EXT_SYNC, SHARED_REFCLK_SELECT, COMPLETION_BOUNDARY_SIZE} == {RDATA[7:6], RDATA[3]}; endproperty
  a_ctl: assert property (p_ctl) else $error("control outputs differ");
  property p_pwr; ok |-> L0S_ENTRY_ENABLE == (RDATA[1:0] == 2'h1); endproperty
  a_pwr: assert property (p_pwr) else $error("entry enable wrong");
  // Vacuous on the first edge after reset, when the latency is not loaded yet
  property p_lat; $past(RST_N) |-> L0S_EXIT_LATENCY ==
    ($past(SHARED_REFCLK_SELECT) ? link_ctl_pkg::L0S_LAT_COMMON : link_ctl_pkg::L0S_LAT_ASYNC); endproperty
  a_lat: assert property (p_lat) else $error("exit latency wrong");
  property p_rd; ARVALID && ARREADY |=> RVALID &&
    RRESP == ($past(ARADDR[11:2]) == link_ctl_pkg::LINK_CSR_OFFSET[11:2] ? 2'h0 : 2'h2); endproperty
  a_rd: assert property (p_rd) else $error("read answer wrong");
endmodule
bind pcie_link_control_status_reg link_csr_chk link_csr_chk_inst (
  .CLK(CLK), .RST_N(RST_N), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .EXT_SYNC(EXT_SYNC),
  .SHARED_REFCLK_SELECT(SHARED_REFCLK_SELECT), .COMPLETION_BOUNDARY_SIZE(COMPLETION_BOUNDARY_SIZE),
  .L0S_ENTRY_ENABLE(L0S_ENTRY_ENABLE), .L0S_EXIT_LATENCY(L0S_EXIT_LATENCY)
);
`default_nettype wire

//--- verification/pcie_link_control_status_reg_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pcie_link_control_status_reg_tb;
  localparam logic [11:0] OFF = link_ctl_pkg::LINK_CSR_OFFSET;
  localparam logic [31:0] RV = link_ctl_pkg::LINK_CSR_RESET;
  logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic SLOT_CLK_LOAD, SLOT_CLK_VALUE, EXT_SYNC, SHARED_REFCLK_SELECT, COMPLETION_BOUNDARY_SIZE, L0S_ENTRY_ENABLE;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [2:0] L0S_EXIT_LATENCY, L1_EXIT_LATENCY;
  int failures = 0;
  int checked = 0;
  pcie_link_control_status_reg pcie_link_control_status_reg_inst (
    .CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .SLOT_CLK_LOAD(SLOT_CLK_LOAD), .SLOT_CLK_VALUE(SLOT_CLK_VALUE),
    .EXT_SYNC(EXT_SYNC), .SHARED_REFCLK_SELECT(SHARED_REFCLK_SELECT),
    .COMPLETION_BOUNDARY_SIZE(COMPLETION_BOUNDARY_SIZE), .L0S_ENTRY_ENABLE(L0S_ENTRY_ENABLE),
    .L0S_EXIT_LATENCY(L0S_EXIT_LATENCY), .L1_EXIT_LATENCY(L1_EXIT_LATENCY)
  );
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // Ready sampled before the edge, so no race with the slave
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    {AWVALID, WVALID, BREADY} <= 3'h7;
    do begin
      @(negedge CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end while ((AWVALID && !aw) || (WVALID && !w));
    do @(negedge CLK); while (!BVALID);
    chk(BRESP, er, "bresp");
    @(posedge CLK);
    BREADY <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge CLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    do @(negedge CLK); while (!ARREADY);
    @(posedge CLK);
    ARVALID <= 1'b0;
    do @(negedge CLK); while (!RVALID);
    chk(RDATA, e, "rdata");
    chk(RRESP, er, "rresp");
    @(posedge CLK);
    RREADY <= 1'b0;
  endtask
  task t_reset;
    rc(OFF, RV, 2'h0);
    chk({EXT_SYNC, SHARED_REFCLK_SELECT, COMPLETION_BOUNDARY_SIZE, L0S_ENTRY_ENABLE}, 4'h0, "ctl");
    chk(L0S_EXIT_LATENCY, link_ctl_pkg::L0S_LAT_ASYNC, "l0s lat");
    chk(L1_EXIT_LATENCY, link_ctl_pkg::L1_LAT_ASYNC, "l1 lat");
  endtask
  task t_rw;
    wr(OFF, 32'hffff_ffff, 4'hf, 2'h0);
    rc(OFF, RV | 32'hcb, 2'h0);
    chk({EXT_SYNC, SHARED_REFCLK_SELECT, COMPLETION_BOUNDARY_SIZE, L0S_ENTRY_ENABLE}, 4'he, "ctl");
    chk(L1_EXIT_LATENCY, link_ctl_pkg::L1_LAT_COMMON, "l1 lat");
    chk(L0S_EXIT_LATENCY, link_ctl_pkg::L0S_LAT_COMMON, "l0s lat");
    wr(OFF, 32'h0, 4'h0, 2'h0);
    rc(OFF, RV | 32'hcb, 2'h0);
  endtask
  task t_codes;
    for (logic [2:0] i = 3'h0; i < 3'h4; i++) begin
      wr(OFF, {29'h0, i}, 4'h1, 2'h0);
      rc(OFF, RV | {29'h0, i}, 2'h0);
      chk(L0S_ENTRY_ENABLE, i == 3'h1, "l0s en");
    end
  endtask
  task t_bad;
    wr(12'h0d4, 32'hffff_ffff, 4'hf, 2'h2);
    rc(12'h0d4, 32'h0, 2'h2);
    rc(OFF, RV | 32'h3, 2'h0);
  endtask
  task t_slot;
    @(posedge CLK);
    {SLOT_CLK_LOAD, SLOT_CLK_VALUE} <= 2'h3;
    @(posedge CLK);
    SLOT_CLK_LOAD <= 1'b0;
    wr(OFF, 32'h0, 4'hf, 2'h0);
    rc(OFF, RV | 32'h1000_0000, 2'h0);
  endtask
  // Reset in mid-run must return every writable bit and the strap bit to zero
  task t_rerst;
    wr(OFF, 32'hcb, 4'h1, 2'h0);
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rc(OFF, RV, 2'h0);
    chk({EXT_SYNC, SHARED_REFCLK_SELECT, COMPLETION_BOUNDARY_SIZE, L0S_ENTRY_ENABLE}, 4'h0, "ctl rst");
  endtask
  task final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLOT_CLK_LOAD, SLOT_CLK_VALUE} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset;
    t_rw;
    t_codes;
    t_bad;
    t_slot;
    t_rerst;
    final_report;
  end
  initial begin
    repeat (3000) @(posedge CLK);
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
